// ==== pmcs_chip_select.sv ====
// Peripheral and midrange chip-select decode with its register file.
// Assumes a classic Wishbone master on mclk and a bus-cycle front end on
// the same clock that pulses bus_addr_latch in the multiplexed address phase.
// Notes on behaviour
// R01: block size field is one-hot, lowest bit 8K, doubling to 512K.
// R02: four midrange selects each cover one consecutive quarter of the block.
// R03: software sets exactly one block size bit, else midrange selects undefined.
// R04: whole-block option makes midrange select 0 cover the entire block.
// R05: pin function 1 gives two upper chip selects, 0 gives A1 and A2.
// R06: address mode pins drive latched A2/A1 after any auxiliary register access.
// R07: memory space bit picks memory cycles or 64K I/O cycles.
// R08: auxiliary ready-ignore bit governs upper selects; waits still inserted.
// R09: auxiliary wait bits add zero to three waits to upper selects.
// R10: each peripheral select spans 256 bytes; slot four is reserved.
// R11: peripheral selects follow multiplexed address phase timing.
// R12: peripheral selects stay off until both registers are written.
// R13: base register bits 15 to 7 give address bits 19 to 11.
// R14: software keeps base bits 19 to 16 zero for I/O mapping.
// R15: extend bit turns codes into 5, 7, 9 or 15 waits.
// R16: base register ready-ignore bit governs lower selects.
// R17: software avoids peripheral overlap with other memory selects.
// R18: software writes ones to auxiliary reserved bits.
// R19: software aligns midrange base to the block size.
// R20: select is low for the whole matching bus cycle, high otherwise.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pmcs_chip_select
	import pmcs_pkg::*;
#(
	parameter int WB_ADDR_W = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bus_cycle_active,
	input wire logic bus_addr_latch,
	input wire logic bus_is_io,
	input wire logic [19:0] bus_addr,
	input wire logic ext_ready_pin,
	output logic [3:0] midrange_select_outputs_n,
	output logic [3:0] lower_peripheral_selects_n,
	output logic [1:0] upper_peripheral_selects_n,
	output logic cycle_ready
);
	// The register decode reads eight address bits, so a narrower bus cannot work.
	if (WB_ADDR_W < 8) begin : g_bad_width
		$error("WB_ADDR_W must be at least 8");
	end

	// ****************************************
	// Register file
	// ****************************************
	logic [15:0] pbase_reg;
	logic [15:0] aux_reg;
	logic [15:0] mid_reg;
	logic pbase_wr_reg;
	logic aux_wr_reg;
	logic aux_acc_reg;
	logic mid_wr_reg;
	logic [3:0] wait_cnt_reg;
	logic wait_ign_reg;
	logic wait_on_reg;
	logic rdy_s1_reg;
	logic rdy_s2_reg;
	logic req;
	logic wr;
	logic [7:0] adr;
	logic [15:0] rd_data;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign adr = wb_adr_i[7:0];

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pbase_reg <= PMCS_RST_REG;
			aux_reg <= PMCS_RST_REG;
			mid_reg <= PMCS_RST_REG;
		end else if (wr) begin
			if (adr == PMCS_OFF_PBASE) begin
				pbase_reg <= merge(pbase_reg, wb_dat_i, wb_sel_i);
			end
			if (adr == PMCS_OFF_AUX) begin
				aux_reg <= merge(aux_reg, wb_dat_i, wb_sel_i);
			end
			if (adr == PMCS_OFF_MID) begin
				mid_reg <= merge(mid_reg, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Activation flags never clear; only reset returns the pins to idle.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pbase_wr_reg <= 1'b0;
			aux_wr_reg <= 1'b0;
			aux_acc_reg <= 1'b0;
			mid_wr_reg <= 1'b0;
		end else begin
			if (wr && adr == PMCS_OFF_PBASE) begin
				pbase_wr_reg <= 1'b1; // see R12
			end
			if (wr && adr == PMCS_OFF_AUX) begin
				aux_wr_reg <= 1'b1; // see R12
			end
			if (req && adr == PMCS_OFF_AUX) begin
				aux_acc_reg <= 1'b1; // see R06
			end
			if (wr && adr == PMCS_OFF_MID) begin
				mid_wr_reg <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_data = 16'h0000;
		unique case (adr)
			PMCS_OFF_PBASE: rd_data = pbase_reg;
			PMCS_OFF_AUX: rd_data = aux_reg;
			PMCS_OFF_MID: rd_data = mid_reg;
			PMCS_OFF_STAT: rd_data = {8'h00, wait_cnt_reg, mid_wr_reg, aux_acc_reg,
				aux_wr_reg, pbase_wr_reg};
			default: rd_data = 16'h0000;
		endcase
	end

	// Every access, mapped or not, is acknowledged one cycle after the request.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? {16'h0000, rd_data} : 32'h0000_0000;
		end
	end

	// ****************************************
	// Address decode
	// ****************************************
	logic periph_on;
	logic pin_sel;
	logic space_ok;
	logic pbase_hit;
	logic [2:0] slot;
	logic mid_blk;
	logic [1:0] mid_q;
	logic [3:0] low_next;
	logic [1:0] up_next;
	logic [3:0] mid_next;

	assign periph_on = pbase_wr_reg && aux_wr_reg; // see R12
	assign pin_sel = aux_reg[PMCS_BIT_PIN]; // see R05
	assign space_ok = aux_reg[PMCS_BIT_MEM] ? !bus_is_io : bus_is_io; // see R07
	assign pbase_hit = bus_addr[19:11] == pbase_reg[15:PMCS_PBASE_LO]; // see R13
	assign slot = bus_addr[PMCS_SLOT_LO +: 3];

	// The block is compared above its size bit and the quarter taken just below.
	always_comb begin
		mid_blk = 1'b0;
		mid_q = 2'h0;
		for (int k = 0; k < PMCS_BSZ_W; k++) begin
			if (aux_reg[PMCS_BSZ_LO + k]) begin // see R01
				mid_blk = (bus_addr >> (PMCS_MID_SHIFT0 + k)) ==
					({mid_reg[15:PMCS_MBASE_LO], 13'h0000} >> (PMCS_MID_SHIFT0 + k));
				mid_q = bus_addr[PMCS_MID_SHIFT0 - 2 + k +: 2]; // see R02
			end
		end
	end

	always_comb begin
		low_next = 4'hf;
		up_next = 2'h3;
		mid_next = 4'hf;
		if (periph_on && space_ok && pbase_hit) begin
			if (slot <= PMCS_SLOT_LAST_LOW) begin
				low_next[slot[1:0]] = 1'b0; // see R10
			end
			if (pin_sel && slot == PMCS_SLOT_UP5) begin
				up_next[0] = 1'b0;
			end
			if (pin_sel && slot == PMCS_SLOT_UP6) begin
				up_next[1] = 1'b0;
			end
		end
		if (aux_acc_reg && !pin_sel) begin
			up_next = {bus_addr[2], bus_addr[1]}; // see R06
		end
		if (mid_wr_reg && aux_acc_reg && !bus_is_io && mid_blk) begin
			mid_next[mid_q] = 1'b0;
			if (mid_reg[PMCS_BIT_WHOLE]) begin
				mid_next[0] = 1'b0; // see R04
			end
		end
	end

	// Selects change one cycle after the multiplexed address phase strobe and
	// hold until the bus cycle ends, so they never lead the AD bus.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lower_peripheral_selects_n <= 4'hf;
			upper_peripheral_selects_n <= 2'h3;
			midrange_select_outputs_n <= 4'hf;
		end else if (bus_addr_latch) begin
			lower_peripheral_selects_n <= low_next; // see R11
			upper_peripheral_selects_n <= up_next;
			midrange_select_outputs_n <= mid_next;
		end else if (!bus_cycle_active) begin
			lower_peripheral_selects_n <= 4'hf; // see R20
			midrange_select_outputs_n <= 4'hf;
			if (pin_sel || !aux_acc_reg) begin
				upper_peripheral_selects_n <= 2'h3;
			end
		end
	end

	// ****************************************
	// Wait states and ready
	// ****************************************
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdy_s1_reg <= 1'b0;
			rdy_s2_reg <= 1'b0;
		end else begin
			rdy_s1_reg <= ext_ready_pin;
			rdy_s2_reg <= rdy_s1_reg;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wait_cnt_reg <= 4'h0;
			wait_ign_reg <= 1'b0;
			wait_on_reg <= 1'b0;
		end else if (bus_addr_latch) begin
			wait_on_reg <= (low_next != 4'hf) || (pin_sel && up_next != 2'h3);
			if (low_next != 4'hf) begin
				wait_cnt_reg <= pmcs_wait(pbase_reg[PMCS_BIT_EXT], pbase_reg[1:0]); // see R15
				wait_ign_reg <= pbase_reg[PMCS_BIT_IGN]; // see R16
			end else begin
				wait_cnt_reg <= {2'h0, aux_reg[1:0]}; // see R09
				wait_ign_reg <= aux_reg[PMCS_BIT_IGN]; // see R08
			end
		end else if (!bus_cycle_active) begin
			wait_on_reg <= 1'b0;
			wait_cnt_reg <= 4'h0;
		end else if (wait_cnt_reg != 4'h0) begin
			wait_cnt_reg <= wait_cnt_reg - 4'h1;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cycle_ready <= 1'b0;
		end else begin
			cycle_ready <= wait_on_reg && bus_cycle_active && !bus_addr_latch &&
				wait_cnt_reg == 4'h0 && (wait_ign_reg || rdy_s2_reg); // see R08
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_off_until_both: assert property (@(posedge mclk) disable iff (reset) // see R12
		!periph_on |-> ##1 lower_peripheral_selects_n == 4'hf)
		else $error("peripheral select active before both registers written");
	a_low_slot_hit: assert property (@(posedge mclk) disable iff (reset) // see R10
		bus_addr_latch && periph_on && space_ok && pbase_hit && slot == 3'h2
		|=> lower_peripheral_selects_n == 4'hb)
		else $error("lower select two not asserted for its slot");
	a_reserved_slot: assert property (@(posedge mclk) disable iff (reset) // see R10
		bus_addr_latch && slot == 3'h4 |=> lower_peripheral_selects_n == 4'hf)
		else $error("select asserted in reserved slot");
	a_wrong_space: assert property (@(posedge mclk) disable iff (reset) // see R07
		bus_addr_latch && !space_ok |=> lower_peripheral_selects_n == 4'hf)
		else $error("select asserted in wrong space");
	a_addr_pins: assert property (@(posedge mclk) disable iff (reset) // see R05
		bus_addr_latch && aux_acc_reg && !pin_sel
		|=> upper_peripheral_selects_n == $past(bus_addr[2:1]))
		else $error("address pins do not carry A2 A1");
	a_ext_waits: assert property (@(posedge mclk) disable iff (reset) // see R15
		bus_addr_latch && low_next != 4'hf && pbase_reg[3:0] == 4'hb
		|=> wait_cnt_reg == 4'hf)
		else $error("extended wait code 11b did not load 15");
	a_upper_waits: assert property (@(posedge mclk) disable iff (reset) // see R09
		bus_addr_latch && low_next == 4'hf && pin_sel && up_next != 2'h3
		|=> wait_cnt_reg == {2'h0, $past(aux_reg[1:0])})
		else $error("upper select wait count wrong");
	a_ready_mode: assert property (@(posedge mclk) disable iff (reset) // see R16
		cycle_ready |-> $past(wait_ign_reg) || $past(rdy_s2_reg))
		else $error("ready given without external ready");
	a_whole_block: assert property (@(posedge mclk) disable iff (reset) // see R04
		bus_addr_latch && mid_next != 4'hf && mid_reg[0] |=> !midrange_select_outputs_n[0])
		else $error("midrange select 0 not over whole block");
	a_sel_hold: assert property (@(posedge mclk) disable iff (reset) // see R20
		lower_peripheral_selects_n != 4'hf && bus_cycle_active && !bus_addr_latch
		|=> $stable(lower_peripheral_selects_n))
		else $error("select changed inside a bus cycle");
	c_lower_hit: cover property (@(posedge mclk) disable iff (reset)
		lower_peripheral_selects_n != 4'hf ##1 cycle_ready);
	c_upper_hit: cover property (@(posedge mclk) disable iff (reset)
		pin_sel && upper_peripheral_selects_n != 2'h3);
	c_mid_hit: cover property (@(posedge mclk) disable iff (reset)
		midrange_select_outputs_n[3] == 1'b0);
endmodule
`default_nettype wire

// ==== pmcs_pkg.sv ====
// Constants for the peripheral and midrange chip-select block.
// Assumes a Wishbone byte address and 16-bit registers in the low lanes.
`default_nettype none
package pmcs_pkg;
	// ****************************************
	// Register byte offsets and reset value
	// ****************************************
	localparam logic [7:0] PMCS_OFF_PBASE = 8'ha4;
	localparam logic [7:0] PMCS_OFF_AUX = 8'ha8;
	localparam logic [7:0] PMCS_OFF_MID = 8'hac;
	localparam logic [7:0] PMCS_OFF_STAT = 8'hb0;
	localparam logic [15:0] PMCS_RST_REG = 16'h0000;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int PMCS_BSZ_LO = 8;
	localparam int PMCS_BSZ_W = 7;
	localparam int PMCS_BIT_PIN = 7;
	localparam int PMCS_BIT_MEM = 6;
	localparam int PMCS_BIT_EXT = 3;
	localparam int PMCS_BIT_IGN = 2;
	localparam int PMCS_PBASE_LO = 7;
	localparam int PMCS_MBASE_LO = 9;
	localparam int PMCS_BIT_WHOLE = 0;
	localparam int PMCS_MID_SHIFT0 = 13;
	localparam int PMCS_SLOT_LO = 8;
	localparam logic [2:0] PMCS_SLOT_LAST_LOW = 3'h3;
	localparam logic [2:0] PMCS_SLOT_UP5 = 3'h5;
	localparam logic [2:0] PMCS_SLOT_UP6 = 3'h6;
	// ****************************************
	// Wait-state encoding
	// ****************************************
	function automatic logic [3:0] pmcs_wait(input logic ext, input logic [1:0] code);
		logic [3:0] w;
		w = {2'h0, code};
		if (ext) begin
			unique case (code)
				2'h0: w = 4'h5;
				2'h1: w = 4'h7;
				2'h2: w = 4'h9;
				2'h3: w = 4'hf;
			endcase
		end
		return w;
	endfunction
endpackage
`default_nettype wire

// ==== pmcs_periph_model.sv ====
// Model of the peripherals behind the selects; it answers with ready late.
// Assumes active-low selects and a delay that the bench sets per cycle.
`timescale 1ns/1ps
`default_nettype none
// ********
// Peripheral model
// ********
module pmcs_periph_model (
	input wire logic mclk,
	input wire logic [3:0] low_sel_n,
	input wire logic [1:0] up_sel_n,
	input wire logic watch_up,
	input wire logic [5:0] delay,
	output logic ready
);
	logic [5:0] cnt_reg = 6'h00;
	logic hit;
	// Upper pins are only selects when the bench says so; as address bits they mean nothing here.
	assign hit = !(&low_sel_n) || (watch_up && !(&up_sel_n));
	// A deselected device lets ready fall, so a stale ready never ends a cycle.
	always_ff @(posedge mclk) begin
		cnt_reg <= hit ? ((cnt_reg == 6'h3f) ? cnt_reg : cnt_reg + 6'h01) : 6'h00;
		ready <= hit && (cnt_reg >= delay);
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the peripheral and midrange chip-select block.
// Assumes the design answers one Wishbone request at a time on mclk.
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench
// ********
module tb_top
	import pmcs_pkg::*;
;
	logic mclk = 1'h0;
	logic reset, cyc, stb, we, act, lat, io, rdy, ack, cready, wup;
	logic [7:0] adr;
	logic [3:0] sel, msel_n, psel_n;
	logic [31:0] wdat, rd;
	logic [19:0] baddr;
	logic [5:0] dly;
	logic [1:0] usel_n;
	logic [15:0] pb, ax, q;
	logic pb_on, ax_on, acc, mid_on, whole;
	int seed, num_errors, checks, tick;
	pmcs_chip_select dut_u (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd),
		.wb_ack_o(ack), .bus_cycle_active(act), .bus_addr_latch(lat), .bus_is_io(io),
		.bus_addr(baddr), .ext_ready_pin(rdy), .midrange_select_outputs_n(msel_n),
		.lower_peripheral_selects_n(psel_n), .upper_peripheral_selects_n(usel_n),
		.cycle_ready(cready));
	pmcs_periph_model model_u (.mclk(mclk), .low_sel_n(psel_n), .up_sel_n(usel_n),
		.watch_up(wup), .delay(dly), .ready(rdy));
	always #10 mclk = ~mclk;
	// The run needs about a thousand cycles; the ceiling leaves wide margin.
	always @(posedge mclk) begin
		tick++;
		if (tick == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		wdat <= {16'h0000, d};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'h1 && n < 40);
		q = rd[15:0];
		if (!w) chk("read upper half", rd[31:16], 16'h0000);
		cyc <= 1'h0;
		stb <= 1'h0;
		if (n == 40) num_errors++;
		acc |= (a == PMCS_OFF_AUX);
		if (w && a == PMCS_OFF_PBASE) {pb_on, pb} = {1'h1, d};
		if (w && a == PMCS_OFF_AUX) {ax_on, ax} = {1'h1, d};
		if (w && a == PMCS_OFF_MID) {mid_on, whole} = {1'h1, d[0]};
	endtask
	function automatic logic [5:0] exp_p(input logic [19:0] a, input logic i);
		logic [5:0] e;
		e = 6'h3f;
		if (pb_on && ax_on && i != ax[6] && a[19:11] == pb[15:7]) begin
			if (a[10:8] < 3'h4) e[a[9:8]] = 1'h0;
			if (ax[7] && (a[10:8] == 3'h5 || a[10:8] == 3'h6)) e[4 + a[9]] = 1'h0;
		end
		if (!ax[7] && acc) e[5:4] = {a[2], a[1]};
		return e;
	endfunction
	function automatic logic [3:0] exp_m(input logic [19:0] a, input logic i);
		logic [3:0] e;
		int k;
		e = 4'hf;
		k = 0;
		for (int b = 0; b < 7; b++) if (ax[8 + b]) k = b;
		if (mid_on && acc && !i && (a >> (13 + k)) == (20'h8_0000 >> (13 + k))) begin
			e[2'(a >> (11 + k))] = 1'h0;
			if (whole) e[0] = 1'h0;
		end
		return e;
	endfunction
	function automatic int exp_w(input logic [2:0] s);
		if (s > 3'h3) return int'(ax[1:0]);
		if (!pb[3]) return int'(pb[1:0]);
		return (pb[1:0] == 2'h3) ? 15 : 5 + 2 * pb[1:0];
	endfunction
	task automatic cr(input logic [19:0] a, input logic i);
		logic [5:0] ep;
		logic ign;
		int w, n;
		ep = exp_p(a, i);
		w = exp_w(a[10:8]);
		ign = (a[10:8] > 3'h3) ? ax[2] : pb[2];
		n = 0;
		@(posedge mclk);
		act <= 1'h1;
		lat <= 1'h1;
		baddr <= a;
		io <= i;
		dly <= ign ? 6'($random(seed) & 31) : 6'h14;
		wup <= ax[7];
		@(posedge mclk);
		lat <= 1'h0;
		#1;
		chk("lower selects", psel_n, ep[3:0]);
		chk("upper pins", usel_n, ep[5:4]);
		chk("midrange selects", msel_n, exp_m(a, i));
		if (ep[3:0] != 4'hf || (ax[7] && ep[5:4] != 2'h3)) begin
			while (cready !== 1'h1 && n < 60) begin
				@(posedge mclk);
				#1;
				n++;
			end
			if (ign) chk("wait states", n, w + 1);
			else chk("ready gated", n > dly + 1 && n <= dly + w + 8, 1);
		end
		@(posedge mclk);
		act <= 1'h0;
		repeat (2) @(posedge mclk);
		#1;
		chk("idle", {ax[7] ? usel_n : 2'h3, psel_n, msel_n, cready}, 11'h7fe);
	endtask
	task automatic cfg(input logic [6:0] size, input logic ex);
		logic [31:0] r;
		r = $random(seed);
		wb(1'h1, PMCS_OFF_PBASE, {4'h0, r[11:7], 3'h7, r[3:0]});
		wb(1'h0, PMCS_OFF_PBASE, 16'h0000);
		chk("base readback", q & 16'hff8f, pb & 16'hff8f);
		wb(1'h1, PMCS_OFF_AUX, {1'h1, size, ex, r[16], 3'h7, r[14:12]});
		wb(1'h0, PMCS_OFF_AUX, 16'h0000);
		chk("aux readback", q & 16'h7fc7, ax & 16'h7fc7);
	endtask
	initial begin
		logic [31:0] r;
		seed = 32'he96e;
		{reset, cyc, stb, we, act, lat, io, wup} = 8'h80;
		{adr, sel, wdat, baddr, dly} = 70'h0;
		{pb, ax, pb_on, ax_on, acc, mid_on, whole} = 37'h0;
		repeat (2) @(posedge mclk);
		reset <= 1'h0;
		wb(1'h0, PMCS_OFF_PBASE, 16'h0000);
		chk("base reset", q, 16'h0000);
		wb(1'h1, 8'h20, 16'hffff);
		wb(1'h0, 8'h20, 16'h0000);
		chk("unmapped read", q, 16'h0000);
		r = $random(seed);
		wb(1'h1, PMCS_OFF_PBASE, {4'h0, r[11:7], 7'h7f});
		cr({pb[15:7], 3'h1, r[7:0]}, 1'h1);
		$display("activation test done");
		for (int k = 0; k < 48; k++) begin
			if (k % 8 == 0) cfg(7'(1 << (k / 8)), 1'($random(seed)));
			r = $random(seed);
			cr(r[20] ? {pb[15:7], r[10:0]} : {r[21] ? 4'h0 : r[19:16], r[15:0]}, r[21]);
		end
		wb(1'h1, PMCS_OFF_PBASE, {pb[15:7], 7'h7b});
		cr({pb[15:7], 3'h2, 8'h00}, !ax[6]);
		wb(1'h1, PMCS_OFF_PBASE, {pb[15:7], 7'h7f});
		cr({pb[15:7], 3'h2, 8'h00}, !ax[6]);
		wb(1'h0, PMCS_OFF_STAT, 16'h0000);
		chk("status flags", q, 16'h0007);
		$display("peripheral decode test done");
		wb(1'h1, PMCS_OFF_MID, 16'h8000);
		wb(1'h0, PMCS_OFF_MID, 16'h0000);
		chk("mid readback", q, 16'h8000);
		for (int k = 0; k < 14; k++) begin
			if (k == 7) wb(1'h1, PMCS_OFF_MID, 16'h8001);
			cfg(7'(1 << (k % 7)), 1'h1);
			repeat (4) begin
				r = $random(seed);
				cr(20'h8_0000 | (r[19:0] >> (6 - k % 7)), 1'h0);
			end
		end
		$display("midrange test done");
		@(posedge mclk);
		reset <= 1'h1;
		{pb, ax, pb_on, ax_on, acc, mid_on, whole} = 37'h0;
		repeat (2) @(posedge mclk);
		reset <= 1'h0;
		cr(r[19:0], 1'h0);
		wb(1'h0, PMCS_OFF_AUX, 16'h0000);
		chk("aux reset", q, 16'h0000);
		wb(1'h0, PMCS_OFF_STAT, 16'h0000);
		chk("status after reset", q, 16'h0004);
		repeat (4) begin
			r = $random(seed);
			cr(r[19:0], r[20]);
		end
		$display("address pin test done");
		give_verdict();
	end
endmodule
`default_nettype wire
